/* File: logic/pmicpc_pkg.sv */
// Purpose: shared constants and carrier types for the pin control logic
// Assumes: 40 MHz core clock
// Notes:   open-drain pins are modelled as output enable, high while pulling low
package pmicpc_pkg;

  localparam int unsigned CLK_HZ        = 40_000_000;
  localparam int unsigned ACK_WINDOW_S  = 5;
  localparam longint unsigned ACK_WINDOW_CYC_L = longint'(ACK_WINDOW_S) * longint'(CLK_HZ);
  localparam int unsigned ACK_WINDOW_CYC = int'(ACK_WINDOW_CYC_L);
  localparam int unsigned ACK_CNT_W      = 28;

  // dac control fields
  localparam int unsigned DAC_SEL_BIT   = 5;
  localparam int unsigned DAC_CTRL_W    = 8;
  localparam int unsigned NUM_BUCK      = 4;

  // ldo control fields and register reset values
  localparam int unsigned LDO2_EN_BIT   = 2;
  localparam int unsigned LDO3_EN_BIT   = 5;
  localparam int unsigned LDO4_EN_BIT   = 2;
  localparam int unsigned LDO_CTRL_W    = 8;
  localparam logic [7:0]  LDO_CTRL_RST  = 8'h00;
  localparam logic [7:0]  DAC_CTRL_RST  = 8'h00;

  localparam int unsigned SYNC_STAGES   = 2;
  localparam int unsigned NUM_EN        = 7;
  localparam int unsigned NUM_RAIL      = 8;

  // synchronised pin bundle
  typedef struct packed {
    logic                button_n;
    logic                host_power_ack;
    logic                standby_select_in;
    logic [NUM_EN-1:0]   enables;
  } pmicpc_pins_t;

  localparam int unsigned PINS_W = $bits(pmicpc_pins_t);

  // fault flags from the analog side
  typedef struct packed {
    logic power_fail;
    logic undervoltage;
    logic overtemp;
  } pmicpc_fault_t;

  typedef enum logic [1:0] {
    PMICPC_OFF   = 2'b00,
    PMICPC_WAIT  = 2'b01,
    PMICPC_ON    = 2'b11,
    PMICPC_DOWN  = 2'b10
  } pmicpc_state_t;

endpackage : pmicpc_pkg

/* File: logic/pmicpc_sync.sv */
// Purpose: two-flop synchroniser for a bundle of pins
// Assumes: single clock domain
// Notes:   stage one feeds only stage two
module pmicpc_sync #(
  parameter int unsigned W = 1
) (
  // clock and reset
  input  wire logic         i_clk,
  input  wire logic         i_resetn,
  // data
  input  wire logic [W-1:0] i_d,
  output logic      [W-1:0] o_q
);

  logic [W-1:0] meta_reg;

  always_ff @(posedge i_clk or negedge i_resetn)
  begin
    if (!i_resetn)
    begin
      meta_reg <= '0;
      o_q      <= '0;
    end
    else
    begin
      meta_reg <= i_d;
      o_q      <= meta_reg;
    end
  end

endmodule : pmicpc_sync

/* File: logic/pmicpc_top.sv */
// Purpose: pin control logic of a multi-rail power manager
// Assumes: pins synchronous-ish, 40 MHz clock, serial supply monitor as a level input
// Notes:   open-drain outputs expressed as pull-low enables
// Function
// - host must raise ack within five seconds of wake, else rails drop.
// - high ack activates wake; low ack shuts wake down.
// - wake releases high on button press or ack request.
// - button input is active low, idle high.
// - standby select low uses bit 5 choice; high forces standby dac registers.
// - alert pulls low on power-fail, undervoltage or overtemperature flags.
// - writing alert clear command releases the alert output unless a fault flag is set in the same cycle.
// - reset pulls low while keep-alive regulator low, during hard reset, or for one cycle on a button press.
// - power ok low if enabled rail below threshold, or slewing unless masked.
// - power ok held low while every regulator is disabled.
// - regulator enable inputs active high, floating reads disabled.
// - ddr variant buck 1 enable also drives termination reference.
// - registers return to power-on values when serial supply collapses.
// - ldo2 runs when enable bit or pin set; default bit zero.
// - ddr variant ldo4 enabled only by its register bit.
module pmicpc_top #(
  parameter int unsigned ACK_CYCLES = pmicpc_pkg::ACK_WINDOW_CYC,
  parameter bit          DDR_VARIANT = 1'b0
) (
  // clock and reset
  input  wire logic                              i_clk,
  input  wire logic                              i_resetn,
  // pins
  input  wire logic                              i_button_n,
  input  wire logic                              i_host_power_ack,
  input  wire logic                              i_standby_select_in,
  input  wire logic [pmicpc_pkg::NUM_EN-1:0]     i_enables,
  // analog status
  input  wire logic                              i_serial_port_supply_ok,
  input  wire logic                              i_keepalive_ok,
  input  wire logic [pmicpc_pkg::NUM_RAIL-1:0]   i_rail_good,
  input  wire logic                              i_slewing,
  input  wire pmicpc_pkg::pmicpc_fault_t         i_fault,
  // register writes from the serial port
  input  wire logic                              i_dac_wr,
  input  wire logic [1:0]                        i_dac_idx,
  input  wire logic [pmicpc_pkg::DAC_CTRL_W-1:0] i_dac_wdata,
  input  wire logic                              i_ldo_ctrl_reg_first_wr,
  input  wire logic                              i_ldo_ctrl_reg_second_wr,
  input  wire logic [pmicpc_pkg::LDO_CTRL_W-1:0] i_ldo_wdata,
  input  wire logic                              i_alert_clear_cmd,
  input  wire logic                              i_hard_reset_cmd,
  input  wire logic                              i_slew_mask,
  // outputs
  output logic                                   o_wake,
  output logic                                   o_alert_pull,
  output logic                                   o_reset_out_n,
  output logic                                   o_power_ok_out,
  output logic [pmicpc_pkg::NUM_BUCK-1:0]        o_dac_use_standby,
  output logic [pmicpc_pkg::NUM_RAIL-1:0]        o_rail_en,
  output logic                                   o_ddr_term_ref_out,
  output pmicpc_pkg::pmicpc_state_t              o_state
);

  pmicpc_pkg::pmicpc_pins_t pins_raw, pins;
  pmicpc_pkg::pmicpc_state_t state_reg, state_next;
  logic [pmicpc_pkg::ACK_CNT_W-1:0] ack_cnt_reg;
  logic [pmicpc_pkg::NUM_BUCK-1:0]  dac_sel_reg;
  logic [pmicpc_pkg::LDO_CTRL_W-1:0] ldo_ctrl_reg_first_reg, ldo_ctrl_reg_second_reg;
  logic button_prev_reg, press, alert_reg;
  logic [pmicpc_pkg::NUM_RAIL-1:0] rail_en;
  logic expired;

  // pin order: b1 b2 b3 b4 l2 l3 l4
  function automatic logic any_set(input logic [pmicpc_pkg::NUM_RAIL-1:0] v);
    any_set = |v;
  endfunction : any_set

  assign pins_raw.button_n          = i_button_n;
  assign pins_raw.host_power_ack    = i_host_power_ack;
  assign pins_raw.standby_select_in = i_standby_select_in;
  assign pins_raw.enables           = i_enables;

  pmicpc_sync #(.W(pmicpc_pkg::PINS_W)) u_sync (
    .i_clk    (i_clk),
    .i_resetn (i_resetn),
    .i_d      (pins_raw),
    .o_q      (pins)
  );

  // history clears low like the synchroniser, so reset release is no press;
  // a button already held at release is ignored until it is let go
  always_ff @(posedge i_clk or negedge i_resetn)
  begin
    if (!i_resetn)
      button_prev_reg <= 1'b0;
    else
      button_prev_reg <= pins.button_n;
  end
  assign press = button_prev_reg & ~pins.button_n;

  assign expired = (ack_cnt_reg >= pmicpc_pkg::ACK_CNT_W'(ACK_CYCLES - 1));

  // wake handshake
  always_comb
  begin
    state_next = state_reg;
    case (state_reg)
      pmicpc_pkg::PMICPC_OFF:
        if (pins.host_power_ack)
          state_next = pmicpc_pkg::PMICPC_ON;
        else if (press)
          state_next = pmicpc_pkg::PMICPC_WAIT;
      pmicpc_pkg::PMICPC_WAIT:
        if (pins.host_power_ack)
          state_next = pmicpc_pkg::PMICPC_ON;
        else if (expired)
          state_next = pmicpc_pkg::PMICPC_DOWN;
      pmicpc_pkg::PMICPC_ON:
        if (!pins.host_power_ack)
          state_next = pmicpc_pkg::PMICPC_DOWN;
      pmicpc_pkg::PMICPC_DOWN:
        state_next = pmicpc_pkg::PMICPC_OFF;
      default:
        state_next = pmicpc_pkg::PMICPC_OFF;
    endcase
  end

  always_ff @(posedge i_clk or negedge i_resetn)
  begin
    if (!i_resetn)
      state_reg <= pmicpc_pkg::PMICPC_OFF;
    else
      state_reg <= state_next;
  end

  // window counter runs only while waiting for the host
  always_ff @(posedge i_clk or negedge i_resetn)
  begin
    if (!i_resetn)
      ack_cnt_reg <= '0;
    else if (state_reg == pmicpc_pkg::PMICPC_WAIT && !expired)
      ack_cnt_reg <= ack_cnt_reg + 1'b1;
    else if (state_reg != pmicpc_pkg::PMICPC_WAIT)
      ack_cnt_reg <= '0;
  end

  // serial registers reset when their supply collapses; gated as a sync clear
  always_ff @(posedge i_clk or negedge i_resetn)
  begin
    if (!i_resetn)
    begin
      ldo_ctrl_reg_first_reg    <= pmicpc_pkg::LDO_CTRL_RST;
      ldo_ctrl_reg_second_reg    <= pmicpc_pkg::LDO_CTRL_RST;
      dac_sel_reg <= '0;
    end
    else if (!i_serial_port_supply_ok)
    begin
      ldo_ctrl_reg_first_reg    <= pmicpc_pkg::LDO_CTRL_RST;
      ldo_ctrl_reg_second_reg    <= pmicpc_pkg::LDO_CTRL_RST;
      dac_sel_reg <= '0;
    end
    else
    begin
      if (i_ldo_ctrl_reg_first_wr)
        ldo_ctrl_reg_first_reg <= i_ldo_wdata;
      if (i_ldo_ctrl_reg_second_wr)
        ldo_ctrl_reg_second_reg <= i_ldo_wdata;
      if (i_dac_wr)
        dac_sel_reg[i_dac_idx] <= i_dac_wdata[pmicpc_pkg::DAC_SEL_BIT];
    end
  end

  // rail enables; wake drives pin-strapped sequences only through enable pins
  always_comb
  begin
    rail_en    = '0;
    rail_en[3:0] = pins.enables[3:0];
    rail_en[4] = pins.enables[4] | ldo_ctrl_reg_first_reg[pmicpc_pkg::LDO2_EN_BIT];
    rail_en[5] = pins.enables[5] | ldo_ctrl_reg_first_reg[pmicpc_pkg::LDO3_EN_BIT];
    rail_en[6] = DDR_VARIANT ? ldo_ctrl_reg_second_reg[pmicpc_pkg::LDO4_EN_BIT]
                             : (pins.enables[6] | ldo_ctrl_reg_second_reg[pmicpc_pkg::LDO4_EN_BIT]);
    rail_en[7] = DDR_VARIANT & pins.enables[0];
    if (state_reg == pmicpc_pkg::PMICPC_DOWN)
      rail_en = '0;
  end

  // registered outputs
  always_ff @(posedge i_clk or negedge i_resetn)
  begin
    if (!i_resetn)
    begin
      o_wake             <= 1'b0;
      o_rail_en          <= '0;
      o_ddr_term_ref_out <= 1'b0;
      o_dac_use_standby  <= '0;
      o_reset_out_n      <= 1'b0;
      o_power_ok_out     <= 1'b0;
      o_state            <= pmicpc_pkg::PMICPC_OFF;
    end
    else
    begin
      o_wake             <= (state_next == pmicpc_pkg::PMICPC_WAIT) ||
                            (state_next == pmicpc_pkg::PMICPC_ON);
      o_rail_en          <= rail_en;
      o_ddr_term_ref_out <= rail_en[7];
      o_dac_use_standby  <= pins.standby_select_in ? '1 : dac_sel_reg;
      o_reset_out_n      <= i_keepalive_ok & ~i_hard_reset_cmd & ~press;
      o_power_ok_out     <= any_set(rail_en) && ((i_rail_good | ~rail_en) == '1) &&
                            !(i_slewing && !i_slew_mask);
      o_state            <= state_next;
    end
  end

  // alert: set wins over a simultaneous clear
  always_ff @(posedge i_clk or negedge i_resetn)
  begin
    if (!i_resetn)
      alert_reg <= 1'b0;
    else if (|i_fault)
      alert_reg <= 1'b1;
    else if (i_alert_clear_cmd || !i_serial_port_supply_ok)
      alert_reg <= 1'b0;
  end
  assign o_alert_pull = alert_reg;

  a_ack_window: assert property (@(posedge i_clk) disable iff (!i_resetn)
    (state_reg == pmicpc_pkg::PMICPC_WAIT && expired && !pins.host_power_ack)
      |=> state_reg == pmicpc_pkg::PMICPC_DOWN) else $error("ack window not enforced");
  a_ack_low_drop: assert property (@(posedge i_clk) disable iff (!i_resetn)
    (state_reg == pmicpc_pkg::PMICPC_ON && !pins.host_power_ack) |=> !o_wake)
    else $error("wake not shut by ack low");
  a_press_wake: assert property (@(posedge i_clk) disable iff (!i_resetn)
    (state_reg == pmicpc_pkg::PMICPC_OFF && press) |=> o_wake) else $error("press did not wake");
  a_standby_force: assert property (@(posedge i_clk) disable iff (!i_resetn)
    pins.standby_select_in |=> o_dac_use_standby == '1) else $error("standby not forced");
  a_alert_sets: assert property (@(posedge i_clk) disable iff (!i_resetn)
    (|i_fault) |=> o_alert_pull) else $error("alert not raised");
  a_alert_clear: assert property (@(posedge i_clk) disable iff (!i_resetn)
    (i_alert_clear_cmd && !(|i_fault)) |=> !o_alert_pull) else $error("alert not cleared");
  a_reset_hold: assert property (@(posedge i_clk) disable iff (!i_resetn)
    (!i_keepalive_ok || i_hard_reset_cmd) |=> !o_reset_out_n) else $error("reset not low");
  a_all_off_low: assert property (@(posedge i_clk) disable iff (!i_resetn)
    (rail_en == '0) |=> !o_power_ok_out) else $error("power ok with all off");
  a_regs_reset: assert property (@(posedge i_clk) disable iff (!i_resetn)
    !i_serial_port_supply_ok |=> (ldo_ctrl_reg_first_reg == pmicpc_pkg::LDO_CTRL_RST && dac_sel_reg == '0))
    else $error("registers not reset");

  c_ack_ok: cover property (@(posedge i_clk) state_reg == pmicpc_pkg::PMICPC_WAIT ##1
    state_reg == pmicpc_pkg::PMICPC_ON);
  c_timeout: cover property (@(posedge i_clk) state_reg == pmicpc_pkg::PMICPC_WAIT ##1
    state_reg == pmicpc_pkg::PMICPC_DOWN);
  c_alert_cycle: cover property (@(posedge i_clk) o_alert_pull ##1 !o_alert_pull);

endmodule : pmicpc_top

/* File: dv/pmicpc_host_model.sv */
// Purpose: host processor model answering the wake output with a power acknowledge
// Assumes: ack delay counted in core clock cycles
// Notes:   ack held low while disabled, so a silent host can be modelled
module pmicpc_host_model (
  // clock
  input  wire logic       i_clk,
  // control from bench
  input  wire logic       i_ack_en,
  input  wire logic [7:0] i_delay,
  // device pins
  input  wire logic       i_wake,
  output logic            o_host_power_ack
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] cnt_reg;
  initial o_host_power_ack = 1'b0;
  initial cnt_reg = 8'h00;
  // slow answer still inside the window; disabled host never answers
  // plain always: the initial values above write the same variables
  always @(posedge i_clk)
  begin
    if (!i_ack_en)
    begin
      cnt_reg          <= 8'h00;
      o_host_power_ack <= 1'b0;
    end
    else if (i_wake && !o_host_power_ack)
    begin
      if (cnt_reg == i_delay)
        o_host_power_ack <= 1'b1;
      else
        cnt_reg <= cnt_reg + 8'h01;
    end
  end
endmodule : pmicpc_host_model

/* File: dv/testbench.sv */
// Purpose: directed bench for the pin control logic
// Assumes: inputs change at the falling edge, short ack window
// Notes:   fixed waits follow the 3-edge pin and 1-edge direct latencies
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int unsigned ACK_CYC = 50;
  logic i_clk = 1'b0, i_resetn = 1'b0, i_button_n = 1'b1, i_standby_select_in = 1'b0;
  logic i_serial_port_supply_ok = 1'b1, i_keepalive_ok = 1'b1, i_slewing = 1'b0;
  logic i_dac_wr = 1'b0, i_ldo_ctrl_reg_first_wr = 1'b0, i_ldo_ctrl_reg_second_wr = 1'b0, i_alert_clear_cmd = 1'b0;
  logic i_hard_reset_cmd = 1'b0, i_slew_mask = 1'b0, ack_en = 1'b1, i_host_power_ack;
  logic [6:0] i_enables = 7'h00;
  logic [7:0] i_rail_good = 8'h00, i_dac_wdata = 8'h00, i_ldo_wdata = 8'h00, o_rail_en;
  logic [1:0] i_dac_idx = 2'h0;
  pmicpc_pkg::pmicpc_fault_t i_fault = '0;
  logic o_wake, o_alert_pull, o_reset_out_n, o_power_ok_out, o_ddr_term_ref_out;
  logic [3:0] o_dac_use_standby;
  pmicpc_pkg::pmicpc_state_t o_state;
  int failures = 0, checks = 0, cycles = 0;
  initial forever #12.5 i_clk = ~i_clk;
  pmicpc_top #(.ACK_CYCLES(ACK_CYC), .DDR_VARIANT(1'b0)) dut_u (
    .i_clk(i_clk), .i_resetn(i_resetn), .i_button_n(i_button_n), .i_host_power_ack(i_host_power_ack),
    .i_standby_select_in(i_standby_select_in), .i_enables(i_enables),
    .i_serial_port_supply_ok(i_serial_port_supply_ok), .i_keepalive_ok(i_keepalive_ok),
    .i_rail_good(i_rail_good), .i_slewing(i_slewing), .i_fault(i_fault), .i_dac_wr(i_dac_wr),
    .i_dac_idx(i_dac_idx), .i_dac_wdata(i_dac_wdata), .i_ldo_ctrl_reg_first_wr(i_ldo_ctrl_reg_first_wr), .i_ldo_ctrl_reg_second_wr(i_ldo_ctrl_reg_second_wr),
    .i_ldo_wdata(i_ldo_wdata), .i_alert_clear_cmd(i_alert_clear_cmd), .i_hard_reset_cmd(i_hard_reset_cmd),
    .i_slew_mask(i_slew_mask), .o_wake(o_wake), .o_alert_pull(o_alert_pull), .o_reset_out_n(o_reset_out_n),
    .o_power_ok_out(o_power_ok_out), .o_dac_use_standby(o_dac_use_standby), .o_rail_en(o_rail_en),
    .o_ddr_term_ref_out(o_ddr_term_ref_out), .o_state(o_state));
  pmicpc_host_model host_u (.i_clk(i_clk), .i_ack_en(ack_en), .i_delay(8'h14), .i_wake(o_wake),
    .o_host_power_ack(i_host_power_ack));
  task automatic check(input string name, input logic [7:0] seen, input logic [7:0] exp);
    checks++;
    if (seen !== exp)
    begin
      failures++;
      $display("[ERR] %s expected %h seen %h", name, exp, seen);
    end
  endtask : check
  task automatic cyc(input int n);
    repeat (n) @(negedge i_clk);
  endtask : cyc
  task automatic report_and_stop();
    $display("checks %0d failures %0d", checks, failures);
    if (failures == 0 && checks > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask : report_and_stop
  // ceiling well above the fewer than two hundred cycles the tests need
  always @(posedge i_clk)
  begin
    cycles++;
    if (cycles == 5000)
    begin
      failures++;
      report_and_stop();
    end
  end
  task automatic press();
    i_button_n = 1'b0;
    cyc(5);
    i_button_n = 1'b1;
  endtask : press
  initial
  begin
    cyc(1);
    check("reset_during", {6'h00, o_reset_out_n, o_power_ok_out}, 8'h00);
    cyc(1);
    i_resetn = 1'b1;
    cyc(2);
    check("idle_wake", o_wake, 8'h00);
    press();
    check("wake_press", o_wake, 8'h01);
    check("state_wait", o_state, pmicpc_pkg::PMICPC_WAIT);
    cyc(30);
    check("state_on", o_state, pmicpc_pkg::PMICPC_ON);
    check("wake_ack", o_wake, 8'h01);
    $display("test wake_ack done");
    i_enables = 7'h01;
    i_rail_good = 8'hff;
    cyc(4);
    check("buck1_en", o_rail_en[0], 8'h01);
    check("pok_good", o_power_ok_out, 8'h01);
    check("ddr_ref_off", o_ddr_term_ref_out, 8'h00);
    i_slewing = 1'b1;
    cyc(2);
    check("pok_slew", o_power_ok_out, 8'h00);
    i_slew_mask = 1'b1;
    cyc(2);
    check("pok_masked", o_power_ok_out, 8'h01);
    i_rail_good = 8'hfe;
    cyc(2);
    check("pok_low_rail", o_power_ok_out, 8'h00);
    i_rail_good = 8'hff;
    i_enables = 7'h00;
    cyc(4);
    check("pok_all_off", o_power_ok_out, 8'h00);
    $display("test power_ok done");
    for (int i = 0; i < 3; i++)
    begin
      i_fault = pmicpc_pkg::pmicpc_fault_t'(3'b001 << i);
      cyc(2);
      check("alert_set", o_alert_pull, 8'h01);
      i_alert_clear_cmd = 1'b1;
      cyc(1);
      i_alert_clear_cmd = 1'b0;
      i_fault = '0;
      cyc(2);
      check("alert_held", o_alert_pull, 8'h01);
      i_alert_clear_cmd = 1'b1;
      cyc(1);
      i_alert_clear_cmd = 1'b0;
      cyc(2);
      check("alert_clear", o_alert_pull, 8'h00);
    end
    $display("test alert done");
    i_keepalive_ok = 1'b0;
    cyc(2);
    check("rst_keepalive", o_reset_out_n, 8'h00);
    i_keepalive_ok = 1'b1;
    i_hard_reset_cmd = 1'b1;
    cyc(2);
    check("rst_hard", o_reset_out_n, 8'h00);
    i_hard_reset_cmd = 1'b0;
    cyc(2);
    check("rst_free", o_reset_out_n, 8'h01);
    $display("test reset_out done");
    i_standby_select_in = 1'b1;
    cyc(4);
    check("dac_forced", o_dac_use_standby, 8'h0f);
    i_standby_select_in = 1'b0;
    i_dac_idx = 2'h2;
    i_dac_wdata = 8'h01 << pmicpc_pkg::DAC_SEL_BIT;
    i_dac_wr = 1'b1;
    cyc(1);
    i_dac_wr = 1'b0;
    cyc(4);
    check("dac_bit5", o_dac_use_standby, 8'h04);
    i_ldo_wdata = 8'h01 << pmicpc_pkg::LDO2_EN_BIT;
    i_ldo_ctrl_reg_first_wr = 1'b1;
    cyc(1);
    i_ldo_ctrl_reg_first_wr = 1'b0;
    cyc(2);
    check("ldo2_bit", o_rail_en[4], 8'h01);
    i_serial_port_supply_ok = 1'b0;
    i_ldo_ctrl_reg_second_wr = 1'b1;
    cyc(1);
    i_ldo_ctrl_reg_second_wr = 1'b0;
    cyc(1);
    check("ldo2_cleared", o_rail_en[4], 8'h00);
    check("ldo4_refused", o_rail_en[6], 8'h00);
    i_serial_port_supply_ok = 1'b1;
    $display("test registers done");
    ack_en = 1'b0;
    cyc(6);
    check("wake_shut", o_wake, 8'h00);
    cyc(4);
    press();
    check("wake_again", o_wake, 8'h01);
    cyc(ACK_CYC - 6);
    check("window_open", o_state, pmicpc_pkg::PMICPC_WAIT);
    cyc(12);
    check("window_wake", o_wake, 8'h00);
    check("window_state", o_state, pmicpc_pkg::PMICPC_OFF);
    $display("test ack_window done");
    report_and_stop();
  end
endmodule : testbench
